// ### logic/sasc_axil_slave.sv
// AXI4-Lite slave front end: accepts one write and one read at a time
// assumes the register file answers read data combinationally from the read address
`timescale 1ns/1ps
`default_nettype none
module sasc_axil_slave (
   input  wire logic                                clk_sys,
   input  wire logic                                arst_n,
   input  wire sasc_pkg::sasc_axil_req_t            axiReq,
   output var  sasc_pkg::sasc_axil_rsp_t            axiRsp,
   output var  sasc_pkg::sasc_reg_wr_t              regWr,
   output var  logic [sasc_pkg::ADDR_W-1:0]         rdAddr,
   input  wire logic [sasc_pkg::DATA_W-1:0]         rdData
);
   import sasc_pkg::*;

   typedef struct packed {
      logic              awHave;
      logic [ADDR_W-1:0] awAddr;
      logic              wHave;
      logic [DATA_W-1:0] wData;
      logic [3:0]        wStrb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
      sasc_reg_wr_t      wr;
   } sasc_slv_state_t;

   sasc_slv_state_t st_q;
   sasc_slv_state_t st_d;

   always_comb begin
      st_d          = st_q;
      st_d.wr.valid = 1'b0;
      // address and data taken in either order
      if (axiReq.awvalid && !st_q.awHave) begin
         st_d.awHave = 1'b1;
         st_d.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && !st_q.wHave) begin
         st_d.wHave = 1'b1;
         st_d.wData = axiReq.wdata;
         st_d.wStrb = axiReq.wstrb;
      end
      if (st_q.bvalid && axiReq.bready) begin
         st_d.bvalid = 1'b0;
      end
      // response follows both halves
      if (st_q.awHave && st_q.wHave && !st_q.bvalid) begin
         st_d.awHave   = 1'b0;
         st_d.wHave    = 1'b0;
         st_d.bvalid   = 1'b1;
         st_d.bresp    = sasc_is_mapped(st_q.awAddr) ? RESP_OKAY : RESP_SLVERR;
         st_d.wr.valid = sasc_is_mapped(st_q.awAddr);
         st_d.wr.addr  = st_q.awAddr;
         st_d.wr.data  = st_q.wData;
         st_d.wr.strb  = st_q.wStrb;
      end
      if (st_q.rvalid && axiReq.rready) begin
         st_d.rvalid = 1'b0;
      end
      if (axiReq.arvalid && !st_q.rvalid) begin
         st_d.rvalid = 1'b1;
         st_d.rdata  = sasc_is_mapped(axiReq.araddr) ? rdData : '0;
         st_d.rresp  = sasc_is_mapped(axiReq.araddr) ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   always_comb begin
      axiRsp.awready = !st_q.awHave;
      axiRsp.wready  = !st_q.wHave;
      axiRsp.bvalid  = st_q.bvalid;
      axiRsp.bresp   = st_q.bresp;
      axiRsp.arready = !st_q.rvalid;
      axiRsp.rvalid  = st_q.rvalid;
      axiRsp.rdata   = st_q.rdata;
      axiRsp.rresp   = st_q.rresp;
      regWr          = st_q.wr;
      rdAddr         = axiReq.araddr;
   end

endmodule
`default_nettype wire

// ### logic/sasc_top.sv
// action set control: enable state, firing and status of four action sets
// assumes trigger pulses and error events come from logic on clk_sys
//
// Overview of operation
// - configuration bit 15 is the repeat flag; 1 repeats, 0 fires once
// - repeating sets fire on every trigger; one-shot sets only on the first
// - one-shot sets disable themselves when they fire until enabled again
// - repeating sets stay enabled after firing
// - a repeating loop stops only through the disable command or the error disable, not drive stop
// - codes 81h to 8Fh enable the sets named by the low-nibble mask
// - codes 91h to 9Fh disable the sets named by the low-nibble mask
// - unmasked sets keep their state and are not fired by activation
// - codes A1h to AFh fire masked sets directly; host enables them first
// - with error-disable option set, an error flag disables every set
// - after error disable, enables are ignored until command 79h clears error
// - all four sets are disabled at reset
// - main status bits 11 to 8 show enable state of sets 3 to 0
// - interrupt-enable bits 15 to 12 request an interrupt per set trigger
// - a disabled set ignores its trigger
// - an enabled set fires its action on each qualifying trigger
// - config bits 3-0 trigger, 8-4 action, 11-9 cross-set fire flags
// - a directly firing set also fires sets n+1, n+2, n+3 named by bits 9-11
// - cross-fired actions start one clock after the originating action
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sasc_top (
   input  wire logic                                  clk_sys,
   input  wire logic                                  arst_n,
   input  wire sasc_pkg::sasc_axil_req_t              axiReq,
   output var  sasc_pkg::sasc_axil_rsp_t              axiRsp,
   input  wire logic [sasc_pkg::NUM_SETS-1:0]         trigPulse,
   input  wire logic                                  errorEvent,
   output var  logic [sasc_pkg::NUM_SETS-1:0]         actionFire,
   output var  logic [sasc_pkg::NUM_SETS-1:0]         intReqPulse,
   output var  sasc_pkg::sasc_cfg_t [sasc_pkg::NUM_SETS-1:0] setCfg,
   output var  logic [15:0]                           mainStatus
);
   import sasc_pkg::*;

   typedef struct packed {
      logic [NUM_SETS-1:0]            setEnable;
      sasc_cfg_t [NUM_SETS-1:0]       cfg;
      logic [15:0]                    parameterLowWord;
      logic [15:0]                    interruptEnableWord;
      logic                           errorFlag;
      logic                           errorDisableOption;
      logic [NUM_SETS-1:0]            crossPend;
      logic [NUM_SETS-1:0]            fire;
      logic [NUM_SETS-1:0]            irq;
   } sasc_state_t;

   sasc_state_t st_q;
   sasc_state_t st_d;

   sasc_reg_wr_t        regWr;
   logic [ADDR_W-1:0]   rdAddr;
   logic [DATA_W-1:0]   rdData;

   sasc_axil_slave u_slave (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .axiReq  (axiReq),
      .axiRsp  (axiRsp),
      .regWr   (regWr),
      .rdAddr  (rdAddr),
      .rdData  (rdData)
   );

   // byte-lane merge for 16-bit registers
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = data[7:0];
      end
      if (strb[1]) begin
         r[15:8] = data[15:8];
      end
      return r;
   endfunction

   // command decode
   logic                cmdWr;
   logic [7:0]          cmdCode;
   logic [NUM_SETS-1:0] cmdMask;
   logic                cmdEnable;
   logic                cmdDisable;
   logic                cmdActivate;
   logic                cmdErrClear;
   logic                cmdOther;
   logic                cmdCfg;
   logic [1:0]          cmdCfgIdx;

   always_comb begin
      cmdWr       = regWr.valid && (regWr.addr == OFF_CMD) && regWr.strb[0];
      cmdCode     = regWr.data[7:0];
      cmdMask     = cmdCode[3:0];
      cmdEnable   = cmdWr && (cmdCode[7:4] == CMD_ENABLE_HI) && (cmdMask != 4'h0);
      cmdDisable  = cmdWr && (cmdCode[7:4] == CMD_DISABLE_HI) && (cmdMask != 4'h0);
      cmdActivate = cmdWr && (cmdCode[7:4] == CMD_ACTIVATE_HI) && (cmdMask != 4'h0);
      cmdErrClear = cmdWr && (cmdCode == CMD_ERR_CLEAR);
      cmdOther    = cmdWr && (cmdCode == CMD_OTHER_SET);
      cmdCfg      = cmdWr && (cmdCode >= CMD_CFG_FIRST) && (cmdCode <= CMD_CFG_LAST);
      cmdCfgIdx   = 2'(cmdCode - CMD_CFG_FIRST);
   end

   // direct firing: own trigger or activation command, only while enabled
   logic [NUM_SETS-1:0] directFire;
   logic [NUM_SETS-1:0] crossReq;
   logic [NUM_SETS-1:0] anyFire;
   logic [NUM_SETS-1:0] trigIrq;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SETS; gi++) begin : g_set
         logic trig;
         logic act;
         assign trig = trigPulse[gi];
         assign act  = cmdActivate && cmdMask[gi];
         // trigger ignored while disabled, fires while enabled
         assign directFire[gi] = st_q.setEnable[gi] && (trig || act);
         // source set s reaches this set through flag (gi - s - 1) mod 4
         always_comb begin
            crossReq[gi] = 1'b0;
            for (int s = 0; s < NUM_SETS; s++) begin
               if (s != gi) begin
                  crossReq[gi] = crossReq[gi] || (directFire[s] &&
                     st_q.cfg[s].crossSetFireFlags[2'(gi - s - 1)]);
               end
            end
         end
         // cross-fired action lands one clock after the originator
         assign anyFire[gi] = directFire[gi] ||
                              (st_q.crossPend[gi] && st_q.setEnable[gi]);
         assign trigIrq[gi] = trig && st_q.setEnable[gi] &&
                              st_q.interruptEnableWord[INTEN_LSB + gi];
      end
   endgenerate

   // next state
   always_comb begin
      st_d           = st_q;
      st_d.fire      = anyFire;
      st_d.irq       = trigIrq;
      st_d.crossPend = crossReq;

      // register writes
      if (regWr.valid && (regWr.addr == OFF_PARAM)) begin
         st_d.parameterLowWord = merge16(st_q.parameterLowWord, regWr.data, regWr.strb);
      end
      if (regWr.valid && (regWr.addr == OFF_INTEN)) begin
         st_d.interruptEnableWord =
            merge16(st_q.interruptEnableWord, regWr.data, regWr.strb);
      end
      if (cmdCfg) begin
         st_d.cfg[cmdCfgIdx] = sasc_cfg_t'(st_q.parameterLowWord);
      end
      if (cmdOther) begin
         st_d.errorDisableOption = st_q.parameterLowWord[ERRDIS_BIT];
      end

      // error flag: a new error wins over the clear
      if (cmdErrClear) begin
         st_d.errorFlag = 1'b0;
      end
      if (errorEvent) begin
         st_d.errorFlag = 1'b1;
      end

      // enable state, lowest priority first so later clears win
      if (cmdEnable && !(st_q.errorDisableOption && st_q.errorFlag)) begin
         st_d.setEnable = st_q.setEnable | cmdMask;
      end
      if (cmdDisable) begin
         st_d.setEnable = st_d.setEnable & ~cmdMask;
      end
      for (int i = 0; i < NUM_SETS; i++) begin
         if (anyFire[i] && !st_q.cfg[i].repeatFlag) begin
            st_d.setEnable[i] = 1'b0;
         end
      end
      // repeating sets are left enabled after firing
      if (st_q.errorDisableOption && st_q.errorFlag) begin
         st_d.setEnable = '0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q                     <= '0;
         st_q.setEnable           <= EN_RST;
         st_q.parameterLowWord    <= PARAM_RST;
         st_q.interruptEnableWord <= INTEN_RST;
         st_q.cfg                 <= {NUM_SETS{CFG_RST}};
      end else begin
         st_q <= st_d;
      end
   end

   // read mux
   always_comb begin
      rdData = '0;
      case (rdAddr)
         OFF_PARAM: begin
            rdData[15:0] = st_q.parameterLowWord;
         end
         OFF_INTEN: begin
            rdData[15:0] = st_q.interruptEnableWord;
         end
         OFF_STATUS: begin
            rdData[15:0] = mainStatus;
         end
         default: begin
            if ((rdAddr >= OFF_CFG0) && (rdAddr <= OFF_CFG3)) begin
               rdData[15:0] = st_q.cfg[2'((rdAddr - OFF_CFG0) >> 2)];
            end
         end
      endcase
   end

   // outputs straight from the state register
   always_comb begin
      actionFire                               = st_q.fire;
      intReqPulse                              = st_q.irq;
      setCfg                                   = st_q.cfg;
      mainStatus                               = '0;
      mainStatus[STAT_EN_LSB +: NUM_SETS]      = st_q.setEnable;
      mainStatus[STAT_ERR_BIT]                 = st_q.errorFlag;
   end

endmodule
`default_nettype wire

// ### pkg/sasc_pkg.sv
// constants, field layouts and carrier types of the action set control block
// assumes one 200 MHz system clock and an AXI4-Lite master on the register side
package sasc_pkg;

   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;
   localparam int NUM_SETS = 4;

   // register byte addresses
   localparam logic [ADDR_W-1:0] OFF_CMD    = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_PARAM  = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_INTEN  = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_CFG0   = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_CFG3   = 8'h1c;

   // command codes
   localparam logic [3:0] CMD_ENABLE_HI   = 4'h8;
   localparam logic [3:0] CMD_DISABLE_HI  = 4'h9;
   localparam logic [3:0] CMD_ACTIVATE_HI = 4'ha;
   localparam logic [7:0] CMD_ERR_CLEAR   = 8'h79;
   localparam logic [7:0] CMD_OTHER_SET   = 8'h22;
   localparam logic [7:0] CMD_CFG_FIRST   = 8'h26;
   localparam logic [7:0] CMD_CFG_LAST    = 8'h29;

   // field positions
   localparam int ERRDIS_BIT   = 7;
   localparam int STAT_ERR_BIT = 1;
   localparam int STAT_EN_LSB  = 8;
   localparam int INTEN_LSB    = 12;

   // reset values
   localparam logic [3:0]  EN_RST    = 4'h0;
   localparam logic [15:0] PARAM_RST = 16'h0000;
   localparam logic [15:0] INTEN_RST = 16'h0000;
   localparam logic [15:0] CFG_RST   = 16'h0000;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // per-set configuration word
   typedef struct packed {
      logic       repeatFlag;
      logic [2:0] zeroBits;
      logic [2:0] crossSetFireFlags;
      logic [4:0] actionCode;
      logic [3:0] triggerSourceCode;
   } sasc_cfg_t;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } sasc_axil_req_t;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } sasc_axil_rsp_t;

   // one accepted register write
   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [3:0]        strb;
   } sasc_reg_wr_t;

   function automatic logic sasc_is_mapped(input logic [ADDR_W-1:0] a);
      return (a[1:0] == 2'b00) && (a <= OFF_CFG3);
   endfunction

endpackage

// ### test/sasc_asserts.sv
// port checker for the action set control block
// assumes one clock domain, bound onto sasc_top
`timescale 1ns/1ps
`default_nettype none
module sasc_asserts (
   input wire logic                     clk_sys,
   input wire logic                     arst_n,
   input wire sasc_pkg::sasc_axil_req_t axiReq,
   input wire sasc_pkg::sasc_axil_rsp_t axiRsp,
   input wire logic [3:0]               trigPulse,
   input wire logic                     errorEvent,
   input wire logic [3:0]               actionFire,
   input wire logic [3:0]               intReqPulse,
   input wire sasc_pkg::sasc_cfg_t [3:0] setCfg,
   input wire logic [15:0]              mainStatus
);
   import sasc_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   sequence wrTaken;
      axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
   endsequence
   sequence rdWait;
      axiRsp.rvalid && !axiReq.rready;
   endsequence
   rst_state_a: assert property ($rose(arst_n) |-> mainStatus == 16'h0000)
      else $error("status not clear after reset");
   status_bits_a: assert property (mainStatus[15:12] == 4'h0 && mainStatus[7:2] == 6'h0
      && !mainStatus[0]) else $error("unused status bits set");
   trig_fire_a: assert property (trigPulse[0] && mainStatus[8] |=> actionFire[0])
      else $error("enabled set did not fire");
   one_shot_a: assert property (actionFire[0] && !setCfg[0].repeatFlag
      |-> ##2 !mainStatus[8]) else $error("one-shot set stayed enabled");
   repeat_keep_a: assert property (actionFire[1] && setCfg[1].repeatFlag
      && mainStatus[9] |=> mainStatus[9]) else $error("repeat set dropped");
   int_cause_a: assert property (|intReqPulse |-> (intReqPulse & ~$past(trigPulse)) == 4'h0)
      else $error("interrupt without trigger");
   err_flag_a: assert property (errorEvent |-> ##[1:2] mainStatus[1])
      else $error("error flag not set");
   cross_fire_a: assert property (actionFire[2] && setCfg[2].crossSetFireFlags[0]
      && mainStatus[11] |=> actionFire[3]) else $error("cross fire missing");
   wr_resp_a: assert property (wrTaken |-> ##2 axiRsp.bvalid)
      else $error("write response late");
   rd_resp_a: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
      else $error("read response late");
   rd_hold_a: assert property (rdWait |=> axiRsp.rvalid && $stable(axiRsp.rdata))
      else $error("read data not held");
endmodule
bind sasc_top sasc_asserts u_asserts (.clk_sys(clk_sys), .arst_n(arst_n), .axiReq(axiReq),
   .axiRsp(axiRsp), .trigPulse(trigPulse), .errorEvent(errorEvent), .actionFire(actionFire),
   .intReqPulse(intReqPulse), .setCfg(setCfg), .mainStatus(mainStatus));
`default_nettype wire

// ### test/sasc_trig_model.sv
// trigger and error source standing for the detectors beside the block
// assumes bench requests change just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module sasc_trig_model (
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic [3:0] fireReq,
   input  wire logic       errReq,
   output var  logic [3:0] trigPulse,
   output var  logic       errorEvent
);
   // one registered pulse per request, low outside requests
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         trigPulse  <= 4'h0;
         errorEvent <= 1'b0;
      end else begin
         trigPulse  <= fireReq;
         errorEvent <= errReq;
      end
   end
endmodule
`default_nettype wire

// ### test/tb_sync_action_set_control.sv
// self-checking bench for the action set control block
// assumes the trigger model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_sync_action_set_control;
   import sasc_pkg::*;
   logic           clk_sys = 1'b0;
   logic           arst_n = 1'b0;
   sasc_axil_req_t req = '0;
   sasc_axil_rsp_t rsp;
   logic [3:0]     fireReq = 4'h0;
   logic           errReq = 1'b0;
   logic [3:0]     trigPulse, actionFire, intReqPulse, en, m;
   logic           errorEvent;
   sasc_cfg_t [3:0] setCfg;
   logic [15:0]    mainStatus;
   logic [33:0]    q[$];
   logic [33:0]    e;
   int             n_mismatch = 0;
   int             comparisons = 0;
   always #2.5 clk_sys = ~clk_sys;
   sasc_trig_model u_trig (.clk_sys(clk_sys), .arst_n(arst_n), .fireReq(fireReq),
      .errReq(errReq), .trigPulse(trigPulse), .errorEvent(errorEvent));
   sasc_top u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .axiReq(req), .axiRsp(rsp),
      .trigPulse(trigPulse), .errorEvent(errorEvent), .actionFire(actionFire),
      .intReqPulse(intReqPulse), .setCfg(setCfg), .mainStatus(mainStatus));
   task automatic results();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic hang(input int n);
      if (n >= 40) begin
         n_mismatch++;
         results();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge clk_sys);
      q.push_back({r, 32'h0});
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) break;
      end
      req.bready <= 1'b0;
      hang(n);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge clk_sys);
      q.push_back({r, d});
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b0;
      // rready comes one cycle late so that read data must stand a wait state
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys);
         if (rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid && req.rready) break;
         if (n == 1) req.rready <= 1'b1;
      end
      req.rready <= 1'b0;
      hang(n);
   endtask
   task automatic st(input logic [3:0] x, input logic er);
      rd(OFF_STATUS, {20'h0, x, 6'h0, er, 1'b0}, RESP_OKAY);
   endtask
   task automatic cfg(input logic [1:0] s, input logic [15:0] w);
      wr(OFF_PARAM, {16'h0, w}, RESP_OKAY);
      wr(OFF_CMD, {24'h0, CMD_CFG_FIRST + {6'h0, s}}, RESP_OKAY);
      @(posedge clk_sys);
      `CHK(setCfg[s], w)
   endtask
   task automatic trig(input logic [3:0] t, f1, f2, ip);
      fireReq <= t;
      @(posedge clk_sys);
      fireReq <= 4'h0;
      repeat (2) @(posedge clk_sys);
      `CHK(actionFire, f1)
      `CHK(intReqPulse, ip)
      @(posedge clk_sys);
      `CHK(actionFire, f2)
   endtask
   always @(posedge clk_sys) begin
      if (rsp.bvalid && req.bready) begin
         e = q.pop_front();
         `CHK({rsp.bresp, 32'h0}, e)
      end
      if (rsp.rvalid && req.rready) begin
         e = q.pop_front();
         `CHK({rsp.rresp, rsp.rdata}, e)
      end
   end
   initial begin
      void'($urandom(11032));
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      st(4'h0, 1'b0);
      rd(OFF_INTEN, 32'h0, RESP_OKAY);
      rd(8'h20, 32'h0, RESP_SLVERR);
      wr(8'h22, 32'h1, RESP_SLVERR);
      rd(OFF_CMD, 32'h0, RESP_OKAY);
      cfg(2'd0, 16'h0021);
      cfg(2'd1, 16'h8032);
      cfg(2'd2, 16'h8243);
      cfg(2'd3, 16'h8050);
      rd(OFF_CFG0, 32'h21, RESP_OKAY);
      en = 4'h0;
      repeat (4) begin
         m = 4'($urandom_range(1, 15));
         wr(OFF_CMD, {24'h0, CMD_ENABLE_HI, m}, RESP_OKAY);
         en = en | m;
         st(en, 1'b0);
         m = 4'($urandom_range(1, 15));
         wr(OFF_CMD, {24'h0, CMD_DISABLE_HI, m}, RESP_OKAY);
         en = en & ~m;
         st(en, 1'b0);
      end
      wr(OFF_CMD, 32'h8f, RESP_OKAY);
      wr(OFF_INTEN, 32'h1000, RESP_OKAY);
      trig(4'h3, 4'h3, 4'h0, 4'h1);
      st(4'he, 1'b0);
      trig(4'h3, 4'h2, 4'h0, 4'h0);
      wr(OFF_CMD, {24'h0, CMD_ACTIVATE_HI, 4'h3}, RESP_OKAY);
      @(posedge clk_sys);
      `CHK(actionFire, 4'h2)
      trig(4'h4, 4'h4, 4'h8, 4'h0);
      wr(OFF_CMD, 32'h92, RESP_OKAY);
      trig(4'h2, 4'h0, 4'h0, 4'h0);
      wr(OFF_PARAM, 32'h80, RESP_OKAY);
      wr(OFF_CMD, {24'h0, CMD_OTHER_SET}, RESP_OKAY);
      errReq <= 1'b1;
      @(posedge clk_sys);
      errReq <= 1'b0;
      repeat (3) @(posedge clk_sys);
      st(4'h0, 1'b1);
      wr(OFF_CMD, 32'h8f, RESP_OKAY);
      st(4'h0, 1'b1);
      wr(OFF_CMD, {24'h0, CMD_ERR_CLEAR}, RESP_OKAY);
      wr(OFF_CMD, 32'h8f, RESP_OKAY);
      st(4'hf, 1'b0);
      arst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      st(4'h0, 1'b0);
      results();
   end
endmodule
`default_nettype wire
